// File: rtl/modem_cfg.svh
// Constants of the half-duplex modem channel controller.
// Assumes a 125 MHz system clock; included by the modules, not by the package.
`ifndef MODEM_CFG_SVH
`define MODEM_CFG_SVH

// ==========================================================================
// Timing
`define CLK_KHZ 125000
`define TICK_MS 20
`define CTS_WAIT_MS 1000
`define TICK_CYCLES (`TICK_MS * `CLK_KHZ)
`define CTS_WAIT_TICKS (`CTS_WAIT_MS / `TICK_MS)

// ==========================================================================
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_NODE 8'h04
`define REG_DELAY 8'h08
`define REG_ACKTO 8'h0C
`define REG_STATUS 8'h10
`define REG_BAUD 8'h14

// ==========================================================================
// Reset values and codes
`define ACKTO_RST 8'h32
`define BAUD_RST 16'h0364
`define NODE_BCAST 8'hFF
`define CRC_POLY 16'hA001
`define CRC_INIT 16'h0000

`endif

// File: rtl/modem_pkg.sv
// Types shared by the modem channel controller and its helpers.
// Assumes modem_cfg.svh for all numeric constants.
package modem_pkg;

  // ========================================================================
  // Modes and states
  typedef enum logic [1:0] {LM_NONE, LM_FULL, LM_HALF} line_mode_t;
  typedef enum logic [2:0] {S_IDLE, S_SEND, S_CTSW, S_TX, S_OFF} hs_state_t;

  // ========================================================================
  // Control register layout, low bit first from mode upward.
  typedef struct packed {
    logic dup_en;
    logic multi;
    logic crc;
    logic par_even;
    line_mode_t mode;
  } ctrl_t;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic par;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic valid;
    logic [7:0] dst;
    logic [7:0] src;
    logic [15:0] tns;
  } pkt_hdr_t;

  // ========================================================================
  // Whole state of the channel controller.
  typedef struct packed {
    hs_state_t st;
    ctrl_t ctrl;
    logic [7:0] node;
    logic [7:0] snd_dly;
    logic [7:0] off_dly;
    logic [7:0] ack_to;
    logic [15:0] baud;
    logic [7:0] cnt;
    logic [7:0] ack_cnt;
    logic ack_wait;
    logic wb_ack;
    logic [31:0] rdata;
    logic start;
    logic abort;
    logic tmo;
    logic rts;
    logic cts_m;
    logic cts_s;
  } chan_state_t;

endpackage : modem_pkg

// File: rtl/tick_gen.sv
// Prescaler that turns the system clock into delay ticks.
// Assumes restart_i comes from logic on the same clock.
`timescale 1ns/1ns
`include "modem_cfg.svh"
module tick_gen #(
  parameter int CYCLES = `TICK_CYCLES
)
(
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Phase control and tick.
  input wire logic restart_i,
  output logic tick_o
);
  localparam int W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t r;
  tick_state_t n;

  // ========================================================================
  // Elaboration check
  if (CYCLES < 1)
  begin : g_bad
    $error("tick_gen needs at least one cycle per tick");
  end

  // ========================================================================
  // Counter
  // Restart zeroes the phase so a delay is measured from its own start.
  always_comb
  begin
    n = r;
    n.tick = 1'b0;
    if (restart_i)
      n.cnt = '0;
    else if (r.cnt == W'(CYCLES - 1))
    begin
      n.cnt = '0;
      n.tick = 1'b1;
    end
    else
      n.cnt = r.cnt + W'(1);
  end

  // State register; the enable freezes the phase.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else if (ce_i)
      r <= n;
  end

  assign tick_o = r.tick;
endmodule : tick_gen

// File: rtl/packet_check.sv
// Parity, packet check value, address match and duplicate filter.
// Assumes byte and header strobes from a receiver on the same clock.
`timescale 1ns/1ns
`include "modem_cfg.svh"
module packet_check
  import modem_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Settings.
  input wire logic par_even_i,
  input wire logic crc_sel_i,
  input wire logic dup_en_i,
  input wire logic [7:0] node_i,
  // Streams.
  input wire logic clear_i,
  input wire rx_byte_t byte_i,
  input wire pkt_hdr_t pkt_i,
  input wire logic [7:0] tx_data_i,
  // Results.
  output logic [15:0] check_o,
  output logic par_bit_o,
  output logic par_err_o,
  output logic hit_o,
  output logic exec_o,
  output logic dup_ack_o
);
  typedef struct packed {
    logic [7:0] sum;
    logic [15:0] crc;
    logic [15:0] check;
    logic [7:0] last_src;
    logic [15:0] last_tns;
    logic last_ok;
    logic par_bit;
    logic par_err;
    logic hit;
    logic exec;
    logic dup;
  } chk_state_t;

  chk_state_t r;
  chk_state_t n;
  logic match;
  logic same;

  // One byte through the reflected CRC.
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      v = v[0] ? ((v >> 1) ^ `CRC_POLY) : (v >> 1);
    return v;
  endfunction : crc_step

  assign match = pkt_i.valid &&
    (pkt_i.dst == node_i || pkt_i.dst == `NODE_BCAST);
  assign same = r.last_ok && pkt_i.src == r.last_src &&
    pkt_i.tns == r.last_tns;

  // ========================================================================
  // Next state
  // A clear and a byte in one cycle: the byte opens the new packet.
  always_comb
  begin
    n = r;
    n.hit = 1'b0;
    n.exec = 1'b0;
    n.dup = 1'b0;
    n.par_bit = par_even_i & (^tx_data_i);
    if (clear_i)
    begin
      n.sum = 8'h00;
      n.crc = `CRC_INIT;
      n.par_err = 1'b0;
    end
    if (byte_i.valid)
    begin
      n.sum = n.sum + byte_i.data;
      n.crc = crc_step(n.crc, byte_i.data);
      if (par_even_i && ((^byte_i.data) != byte_i.par))
        n.par_err = 1'b1;
    end
    n.check = crc_sel_i ? n.crc : {8'h00, 8'h00 - n.sum};
    if (match)
    begin
      n.hit = 1'b1;
      if (dup_en_i && same)
        n.dup = 1'b1;
      else
        n.exec = 1'b1;
      n.last_src = pkt_i.src;
      n.last_tns = pkt_i.tns;
      n.last_ok = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else if (ce_i)
      r <= n;
  end

  assign check_o = r.check;
  assign par_bit_o = r.par_bit;
  assign par_err_o = r.par_err;
  assign hit_o = r.hit;
  assign exec_o = r.exec;
  assign dup_ack_o = r.dup;

  // ========================================================================
  // Checks
  chk_dup_no_exec: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && match && dup_en_i && same |=> dup_ack_o && !exec_o)
    else $error("repeated packet was executed");
  cov_dup: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    dup_ack_o);
endmodule : packet_check

// File: rtl/modem_chan_ctrl.sv
// Half-duplex modem channel controller with a classic Wishbone slave.
// Assumes a packet engine that starts on TX_START_O and reports the last
// character with TX_DONE_I, and a modem whose CTS is asynchronous.
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "modem_cfg.svh"

module modem_chan_ctrl
  import modem_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
)
(
  // Clock, reset and enable.
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // Wishbone slave.
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Modem pins.
  input wire logic CTS_I,
  output logic RTS_O,
  // Transmit control.
  input wire logic TX_REQ_I,
  input wire logic TX_DONE_I,
  input wire logic [7:0] TX_DATA_I,
  output logic TX_START_O,
  output logic TX_ABORT_O,
  output logic TX_PAR_O,
  // Acknowledge and poll response timer.
  input wire logic ACK_WAIT_I,
  input wire logic RESP_I,
  output logic ACK_TIMEOUT_O,
  // Receive checking.
  input wire logic RX_CLEAR_I,
  input wire rx_byte_t RX_BYTE_I,
  input wire pkt_hdr_t RX_PKT_I,
  output logic [15:0] RX_CHECK_O,
  output logic RX_PAR_ERR_O,
  output logic RX_HIT_O,
  output logic RX_EXEC_O,
  output logic RX_DUP_ACK_O,
  // Settings seen by the framer and poll engine.
  output logic PAR_EN_O,
  output logic MULTI_MSG_O,
  output logic [15:0] BAUD_DIV_O
);
  localparam int CTS_TICKS = `CTS_WAIT_TICKS;

  chan_state_t r;
  chan_state_t n;
  logic hs_tick;
  logic ack_tick;
  logic hs_restart;
  logic ack_restart;
  logic [8:0] cnt_inc;
  logic [8:0] ack_inc;
  logic half;

  assign cnt_inc = {1'b0, r.cnt} + 9'h001;
  assign ack_inc = {1'b0, r.ack_cnt} + 9'h001;
  assign half = (r.ctrl.mode == LM_HALF);

  // ==========================================================================
  // Tick sources
  // Each timer has its own prescaler so one phase never steals a partial
  // tick from another.
  tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_hs_tick (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .restart_i(hs_restart),
    .tick_o(hs_tick)
  );

  tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_ack_tick (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .restart_i(ack_restart),
    .tick_o(ack_tick)
  );

  // The acknowledge prescaler idles at phase zero.
  assign ack_restart = ACK_WAIT_I || !r.ack_wait;

  // ==========================================================================
  // Receive checking
  packet_check u_check (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .par_even_i(r.ctrl.par_even),
    .crc_sel_i(r.ctrl.crc),
    .dup_en_i(r.ctrl.dup_en),
    .node_i(r.node),
    .clear_i(RX_CLEAR_I),
    .byte_i(RX_BYTE_I),
    .pkt_i(RX_PKT_I),
    .tx_data_i(TX_DATA_I),
    .check_o(RX_CHECK_O),
    .par_bit_o(TX_PAR_O),
    .par_err_o(RX_PAR_ERR_O),
    .hit_o(RX_HIT_O),
    .exec_o(RX_EXEC_O),
    .dup_ack_o(RX_DUP_ACK_O)
  );

  // ==========================================================================
  // Next state
  always_comb
  begin
    n = r;
    n.start = 1'b0;
    n.abort = 1'b0;
    n.tmo = 1'b0;
    n.wb_ack = 1'b0;
    n.cts_m = CTS_I;
    n.cts_s = r.cts_m;

    // Bus slave: one wait state, unmapped reads return zero.
    if (CYC_I && STB_I && !r.wb_ack)
    begin
      n.wb_ack = 1'b1;
      n.rdata = 32'h0000_0000;
      case (ADR_I)
        `REG_CTRL:
        begin
          n.rdata = 32'(r.ctrl);
          if (WE_I && SEL_I[0])
            n.ctrl = ctrl_t'(DAT_I[$bits(ctrl_t)-1:0]);
        end
        `REG_NODE:
        begin
          n.rdata = 32'(r.node);
          if (WE_I && SEL_I[0] && DAT_I[7:0] != `NODE_BCAST)
            n.node = DAT_I[7:0];
        end
        `REG_DELAY:
        begin
          n.rdata = 32'({r.off_dly, r.snd_dly});
          if (WE_I && SEL_I[0])
            n.snd_dly = DAT_I[7:0];
          if (WE_I && SEL_I[1])
            n.off_dly = DAT_I[15:8];
        end
        `REG_ACKTO:
        begin
          n.rdata = 32'(r.ack_to);
          if (WE_I && SEL_I[0])
            n.ack_to = DAT_I[7:0];
        end
        `REG_BAUD:
        begin
          n.rdata = 32'(r.baud);
          if (WE_I && SEL_I[0])
            n.baud[7:0] = DAT_I[7:0];
          if (WE_I && SEL_I[1])
            n.baud[15:8] = DAT_I[15:8];
        end
        `REG_STATUS:
          n.rdata = 32'({r.ack_wait, r.rts, r.cts_s, r.st});
        default:
          n.rdata = 32'h0000_0000;
      endcase
    end

    // Handshake sequencer.
    case (r.st)
      S_IDLE:
        if (TX_REQ_I && !r.abort) // Requester drops only after the abort.
        begin
          case (r.ctrl.mode)
            LM_HALF:
              // Delays only exist in this mode.
              n.st = (r.snd_dly == 8'h00) ? S_CTSW : S_SEND;
            LM_FULL:
              if (r.cts_s)
              begin
                n.st = S_TX;
                n.start = 1'b1;
              end
            default:
            begin
              n.st = S_TX;
              n.start = 1'b1;
            end
          endcase
        end
      S_SEND:
        if (hs_tick)
        begin
          if (cnt_inc >= {1'b0, r.snd_dly})
            n.st = S_CTSW;
          else
            n.cnt = cnt_inc[7:0];
        end
      S_CTSW:
        if (r.cts_s)
        begin
          n.st = S_TX;
          n.start = 1'b1;
        end
        else if (hs_tick)
        begin
          if (cnt_inc >= 9'(CTS_TICKS))
          begin
            n.st = S_IDLE;
            n.abort = 1'b1;
          end
          else
            n.cnt = cnt_inc[7:0];
        end
      S_TX:
        if (TX_DONE_I)
          n.st = (half && r.off_dly != 8'h00) ? S_OFF : S_IDLE;
      S_OFF:
        if (hs_tick)
        begin
          if (cnt_inc >= {1'b0, r.off_dly})
            n.st = S_IDLE;
          else
            n.cnt = cnt_inc[7:0];
        end
      default:
        n.st = S_IDLE;
    endcase

    // Every phase change starts its delay from zero.
    if (n.st != r.st)
      n.cnt = 8'h00;
    hs_restart = (n.st != r.st) || (r.st == S_IDLE);

    // RTS follows the mode that will be in force next cycle.
    case (n.ctrl.mode)
      LM_FULL:
        n.rts = 1'b1;
      LM_HALF:
        n.rts = (n.st != S_IDLE);
      default:
        n.rts = 1'b0;
    endcase

    // Acknowledge or poll response timer; a new start wins over a reply.
    if (ACK_WAIT_I)
    begin
      n.ack_wait = 1'b1;
      n.ack_cnt = 8'h00;
    end
    else if (r.ack_wait)
    begin
      if (RESP_I)
        n.ack_wait = 1'b0;
      else if (ack_tick)
      begin
        if (ack_inc >= {1'b0, r.ack_to})
        begin
          n.tmo = 1'b1;
          n.ack_wait = 1'b0;
        end
        else
          n.ack_cnt = ack_inc[7:0];
      end
    end
  end

  // State register; the enable freezes everything.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      r <= '0;
      r.ack_to <= `ACKTO_RST;
      r.baud <= `BAUD_RST;
    end
    else if (CE_I)
      r <= n;
  end

  // ==========================================================================
  // Outputs
  assign DAT_O = r.rdata;
  assign ACK_O = r.wb_ack;
  assign RTS_O = r.rts;
  assign TX_START_O = r.start;
  assign TX_ABORT_O = r.abort;
  assign ACK_TIMEOUT_O = r.tmo;
  assign PAR_EN_O = r.ctrl.par_even;
  assign MULTI_MSG_O = r.ctrl.multi;
  assign BAUD_DIV_O = r.baud;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  chk_none_rts_low: assert property (
    r.ctrl.mode == LM_NONE |-> !RTS_O)
    else $error("RTS active in no-handshake mode");
  chk_full_rts_high: assert property (
    r.ctrl.mode == LM_FULL |-> RTS_O)
    else $error("RTS inactive in full-duplex mode");
  chk_half_rts_idle: assert property (
    half && r.st == S_IDLE |-> !RTS_O)
    else $error("RTS active outside a transmission");
  chk_start_cts_seen: assert property (
    TX_START_O && r.ctrl.mode != LM_NONE |-> $past(r.cts_s))
    else $error("transmission started without CTS");
  chk_abort_one_sec: assert property (
    TX_ABORT_O |-> $past(r.cnt) == 8'(CTS_TICKS - 1) && !TX_START_O)
    else $error("abort not at the one second limit");
  chk_abort_rts_off: assert property (
    TX_ABORT_O && half |-> !RTS_O && r.st == S_IDLE)
    else $error("RTS still active after abort");
  chk_zero_delay: assert property (
    CE_I && r.st == S_IDLE && TX_REQ_I && !TX_ABORT_O && half
    && r.snd_dly == 8'h00 |=> r.st == S_CTSW)
    else $error("zero send delay did not go to CTS wait");
  chk_send_delay: assert property (
    r.st == S_SEND ##1 r.st == S_CTSW |-> $past(cnt_inc) >= $past(r.snd_dly))
    else $error("send delay ended early");
  chk_off_hold: assert property (
    CE_I && r.st == S_TX && TX_DONE_I && half && r.off_dly != 8'h00
    && !(CYC_I && STB_I && WE_I) |=> r.st == S_OFF && RTS_O)
    else $error("RTS not held for off delay");
  chk_node_bcast: assert property (
    r.node != `NODE_BCAST)
    else $error("broadcast address assigned to station");
  chk_tmo_cause: assert property (
    ACK_TIMEOUT_O |-> $past(r.ack_wait) && !r.ack_wait)
    else $error("timeout without a pending wait");
  chk_wb_ack_pulse: assert property (
    ACK_O |=> !ACK_O)
    else $error("bus acknowledge held two cycles");

  cov_half_start: cover property (half && TX_START_O);
  cov_abort: cover property (TX_ABORT_O);
  cov_off_delay: cover property (r.st == S_OFF ##1 r.st == S_IDLE);
  cov_timeout: cover property (ACK_TIMEOUT_O);
endmodule : modem_chan_ctrl

// File: tb/modem_partner.sv
// Behavioural half-duplex modem that answers RTS with CTS.
// Assumes the bench sets the key-up time and may silence the modem.
`timescale 1ns/1ns
module modem_partner
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bench control.
  input wire logic mute_i,
  input wire logic [7:0] keyup_i,
  // Modem pins.
  input wire logic rts_i,
  output logic cts_o
);
  logic [7:0] cnt_reg;
  // ========================================================================
  // Key-up timer, restarted whenever RTS is low.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !rts_i)
      cnt_reg <= 8'h00;
    else if (cnt_reg != 8'hFF)
      cnt_reg <= cnt_reg + 8'h01;
  end
  // CTS falls with RTS; a muted modem never answers, forcing an abort in half duplex.
  assign cts_o = rts_i && !mute_i && (cnt_reg >= keyup_i);
endmodule : modem_partner

// File: tb/half_duplex_modem_channel_control_tb.sv
// Self-checking bench for the modem channel controller.
// Assumes TICK_CYCLES of 4, so one tick is 4 cycles and 1 s is 200.
`timescale 1ns/1ns
module half_duplex_modem_channel_control_tb import modem_pkg::*;;
  logic clk, rst_n, cyc, stb, we, ack, cts, rts, mute;
  logic tx_req, tx_start, tx_abort, tx_par, ack_tmo, par_err;
  logic hit, exec_p, dup, par_en, multi;
  logic [3:0] pl;
  logic [7:0] adr, tx_data, keyup;
  logic [31:0] wdat, rdat, dato;
  logic [15:0] rx_check, baud;
  rx_byte_t rx_byte;
  pkt_hdr_t rx_pkt;
  int fails, n_compared, cycles, n;
  modem_chan_ctrl #(.TICK_CYCLES(4)) dut (
    .CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(dato),
    .ACK_O(ack), .CTS_I(cts), .RTS_O(rts), .TX_REQ_I(tx_req),
    .TX_DONE_I(pl[3]), .TX_DATA_I(tx_data), .TX_START_O(tx_start),
    .TX_ABORT_O(tx_abort), .TX_PAR_O(tx_par), .ACK_WAIT_I(pl[0]),
    .RESP_I(pl[1]), .ACK_TIMEOUT_O(ack_tmo), .RX_CLEAR_I(pl[2]),
    .RX_BYTE_I(rx_byte), .RX_PKT_I(rx_pkt), .RX_CHECK_O(rx_check),
    .RX_PAR_ERR_O(par_err), .RX_HIT_O(hit), .RX_EXEC_O(exec_p),
    .RX_DUP_ACK_O(dup), .PAR_EN_O(par_en), .MULTI_MSG_O(multi),
    .BAUD_DIV_O(baud));
  modem_partner modem (.clk_i(clk), .rst_n_i(rst_n), .mute_i(mute),
    .keyup_i(keyup), .rts_i(rts), .cts_o(cts));
  // ========================================================================
  // Clock and hang guard; a run is well under 5000 cycles.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      give_verdict();
    end
  end
  // ========================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rng(input int v, lo, hi, input string what);
    chk(32'(v >= lo && v <= hi), 32'h1, what);
  endtask : rng
  // Classic cycle; ack is sampled at the edge, then everything drops.
  // No cycle limit here: only the hang guard ends a wait for ack.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string what);
    wb(1'b0, a, 32'h0);
    chk(rdat, e, what);
  endtask : rd
  // Counts edges until the chosen event, or gives up at lim.
  task automatic cnt_until(input int sel, lim, output int c);
    logic s;
    c = 0;
    s = 1'b0;
    while (!s && c < lim)
    begin
      @(posedge clk);
      c++;
      s = sel == 0 ? tx_start === 1'b1 : sel == 1 ? tx_abort === 1'b1 :
          sel == 2 ? rts === 1'b0 : ack_tmo === 1'b1;
    end
  endtask : cnt_until
  task automatic send(input int sel, lim, output int c);
    @(posedge clk);
    tx_req <= 1'b1;
    cnt_until(sel, lim, c);
    tx_req <= 1'b0;
  endtask : send
  // Strobes: bit 0 ack wait, 1 response, 2 receive clear, 3 done.
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    pl <= m;
    @(posedge clk);
    pl <= 4'h0;
  endtask : pulse
  task automatic rxb(input logic [8:0] pd);
    @(posedge clk);
    rx_byte <= {1'b1, pd};
    @(posedge clk);
    rx_byte.valid <= 1'b0;
  endtask : rxb
  task automatic hdr(input logic [7:0] dst, src, input logic [2:0] e);
    @(posedge clk);
    rx_pkt <= {1'b1, dst, src, 16'h1234};
    @(posedge clk);
    rx_pkt.valid <= 1'b0;
    @(posedge clk);
    chk({hit, exec_p, dup}, e, "hit exec dup");
  endtask : hdr
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // ========================================================================
  // Main sequence
  initial
  begin
    {rst_n, cyc, stb, we, tx_req, mute, pl} = '0;
    {adr, tx_data, keyup, wdat, rx_byte, rx_pkt} = '0;
    {fails, n_compared, cycles} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h0C, 32'h32, "ack timeout reset");
    rd(8'h14, 32'h0364, "baud reset");
    rd(8'h18, 32'h0, "unmapped");
    wr(8'h04, 32'hFE);
    wr(8'h04, 32'hFF);
    rd(8'h04, 32'hFE, "node");
    wr(8'h14, 32'h1234);
    chk(baud, 16'h1234, "baud out");
    $display("test registers done");
    // No handshake: CTS stays low yet the start comes at once.
    mute <= 1'b1;
    send(0, 10, n);
    chk(n, 2, "none start");
    chk(rts, 1'b0, "none rts");
    pulse(4'h8);
    // Full duplex with delays set: they must be ignored.
    wr(8'h08, 32'h0203);
    wr(8'h00, 32'h1);
    @(posedge clk);
    chk(rts, 1'b1, "full rts");
    tx_req <= 1'b1;
    cnt_until(0, 30, n);
    chk(n, 30, "full waits cts");
    mute <= 1'b0;
    cnt_until(0, 20, n);
    tx_req <= 1'b0;
    rng(n, 1, 8, "full start");
    pulse(4'h8);
    repeat (3) @(posedge clk);
    chk(rts, 1'b1, "full rts after");
    $display("test none and full done");
    // Half duplex, send delay 3 ticks, off delay 2 ticks.
    wr(8'h00, 32'h2);
    @(posedge clk);
    chk(rts, 1'b0, "half idle rts");
    send(0, 40, n);
    rng(n, 12, 20, "send delay");
    pulse(4'h8);
    cnt_until(2, 40, n);
    rng(n, 7, 14, "off delay");
    repeat (4) @(posedge clk);
    chk(rts, 1'b0, "half rts after");
    // Late CTS inside the one-second limit.
    wr(8'h08, 32'h0001);
    keyup <= 8'd100;
    send(0, 300, n);
    rng(n, 100, 112, "late cts");
    pulse(4'h8);
    cnt_until(2, 5, n);
    rng(n, 1, 2, "zero off delay");
    // Zero send delay: start follows CTS, and a silent modem aborts.
    wr(8'h08, 32'h0);
    keyup <= 8'd20;
    send(0, 60, n);
    rng(n, 20, 28, "zero send delay");
    pulse(4'h8);
    mute <= 1'b1;
    send(1, 400, n);
    rng(n, 199, 210, "abort time");
    chk(rts, 1'b0, "abort rts");
    repeat (2) @(posedge clk);
    chk(rts, 1'b0, "no retry after abort");
    mute <= 1'b0;
    $display("test half duplex done");
    // Parity out, block sum, parity error, CRC.
    wr(8'h00, 32'h4);
    tx_data <= 8'h07;
    repeat (2) @(posedge clk);
    chk({par_en, tx_par}, 2'b11, "parity on");
    pulse(4'h4);
    rxb({1'b1, 8'h01});
    rxb({1'b1, 8'h02});
    @(posedge clk);
    chk(rx_check, 16'h00FD, "block sum");
    chk(par_err, 1'b0, "good parity");
    rxb({1'b0, 8'h01});
    @(posedge clk);
    chk(par_err, 1'b1, "bad parity");
    wr(8'h00, 32'h8);
    pulse(4'h4);
    rxb({1'b1, 8'h01});
    @(posedge clk);
    chk(rx_check, 16'hC0C1, "crc");
    chk({par_en, tx_par}, 2'b00, "parity off");
    $display("test checks done");
    // Poll mode, address match and duplicate filter.
    wr(8'h04, 32'h05);
    wr(8'h00, 32'h30);
    chk(multi, 1'b1, "multi");
    hdr(8'h05, 8'h09, 3'b110);
    hdr(8'h05, 8'h09, 3'b101);
    hdr(8'h07, 8'h09, 3'b000);
    hdr(8'hFF, 8'h03, 3'b110);
    wr(8'h00, 32'h0);
    chk(multi, 1'b0, "single");
    hdr(8'h05, 8'h09, 3'b110);
    hdr(8'h05, 8'h09, 3'b110);
    $display("test packets done");
    // Acknowledge timer, then a response that cancels it.
    wr(8'h0C, 32'h3);
    pulse(4'h1);
    cnt_until(3, 100, n);
    rng(n, 11, 16, "ack timeout");
    pulse(4'h1);
    pulse(4'h2);
    cnt_until(3, 40, n);
    chk(n, 40, "response stops timer");
    $display("test timer done");
    give_verdict();
  end
endmodule : half_duplex_modem_channel_control_tb
